// file: hdl/card_sram_map.vh
// Register offsets, field positions and reset values of the external port
`ifndef CARD_SRAM_MAP_VH
`define CARD_SRAM_MAP_VH

`define OFS_COMMON_CONTROL     8'h00
`define OFS_AREA5_BUS_CONTROL  8'h04
`define OFS_AREA6_BUS_CONTROL  8'h08
`define OFS_AREA5_WAIT_CONTROL 8'h0C
`define OFS_AREA6_WAIT_CONTROL 8'h10
`define OFS_AREA_BUS_CONTROL   8'h14
`define OFS_AREA_WAIT_CONTROL  8'h18
`define OFS_STATUS             8'h1C

`define RST_CONTROL            32'h0000_0000

// common_control
`define CC_MAP_SELECT          0
`define CC_BIG_ENDIAN          1

// area bus control fields
`define BC_IDLE_AFTER_WRITE    29:28
`define BC_IDLE_RD_WR_OTHER    27:26
`define BC_IDLE_RD_WR_SAME     25:24
`define BC_IDLE_RD_RD_OTHER    23:22
`define BC_IDLE_RD_RD_SAME     21:20
`define BC_MEMORY_KIND         15:12
`define BC_BUS_WIDTH_HI        10
`define BC_BUS_WIDTH_LO        9

// area wait control fields
`define WC_LOWER_HALF_KIND     0
`define WC_UPPER_HALF_KIND     1
`define WC_SOFT_WAIT           5:2
`define WC_SETUP_DELAY         9:6
`define WC_END_HOLD            13:10
`define WC_WRITE_HOLD          17:16
`define WC_BYTE_STROBE_STYLE   20

`define KIND_PC_CARD           4'h5
`define AREA_CARD_A            3'h5
`define AREA_CARD_B            3'h6
// Setup delay counts from which the wide-I/O indication is sampled
`define SETUP_SAMPLE_MIN       4'h2

`endif

// file: hdl/cycle_counter.v
// Loadable down counter that times the phases of an external cycle
`timescale 1ns/1ps
module cycle_counter #(
  parameter W = 4
) (
  input  wire         clk,
  input  wire         reset,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output wire         zero
);
  reg [W-1:0] cnt_reg;

  assign zero = (cnt_reg == {W{1'b0}});

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt_reg <= {W{1'b0}};
    else if (load)
      cnt_reg <= load_val;
    else if (!zero)
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
  end
endmodule

// file: hdl/card_sram_port.v
// External bus port: byte-select SRAM, PC card areas and idle insertion
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "card_sram_map.vh"

module card_sram_port (
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        req_valid,
  input  wire [28:0] req_addr,
  input  wire        req_write,
  input  wire        req_word,
  input  wire [15:0] req_wdata,
  output wire        req_ready,
  output reg         req_done,
  output reg  [15:0] req_rdata,
  output wire        bus_clock_out,
  output reg  [25:0] ext_addr,
  output reg  [15:0] data_out,
  input  wire [15:0] data_in,
  output reg         data_oe_n,
  output reg  [7:0]  area_select_n,
  output reg         rd_n,
  output reg         rd_wr_n,
  output reg  [1:0]  byte_enable_n,
  output reg         card_io_read_n,
  output reg         card_io_write_n,
  output reg         slot_a_enable_lower_n,
  output reg         slot_a_enable_upper_n,
  output reg         slot_b_enable_lower_n,
  output reg         slot_b_enable_upper_n,
  input  wire        wait_n,
  input  wire        card_wide_io_indication
);
  localparam S_IDLE  = 6'h01;
  localparam S_GAP   = 6'h02;
  localparam S_SETUP = 6'h04;
  localparam S_STRB  = 6'h08;
  localparam S_HOLD  = 6'h10;
  localparam S_DONE  = 6'h20;

  reg [31:0] common_control_reg;
  reg [31:0] area5_bus_control_reg;
  reg [31:0] area6_bus_control_reg;
  reg [31:0] area5_wait_control_reg;
  reg [31:0] area6_wait_control_reg;
  reg [31:0] area_bus_control_reg;
  reg [31:0] area_wait_control_reg;

  reg [5:0]  state_reg;
  reg [5:0]  state_next;
  reg [25:0] addr_reg;
  reg [2:0]  area_reg;
  reg        write_reg;
  reg        word_reg;
  reg [15:0] wdata_reg;
  reg        card_reg;
  reg        io_reg;
  reg        narrow_reg;
  reg        split_reg;
  reg        second_reg;
  reg        prev_valid_reg;
  reg        prev_write_reg;
  reg [2:0]  prev_area_reg;
  reg [1:0]  wait_sync_reg;
  reg [1:0]  wide_sync_reg;
  reg        sample_reg;

  reg        cnt_load;
  reg [3:0]  cnt_val;
  wire       cnt_zero;

  // Bus control of an area; areas other than 5 and 6 share one set
  function [31:0] bus_ctl;
    input [2:0]  area;
    input [31:0] bc5;
    input [31:0] bc6;
    input [31:0] bco;
    begin
      if (area == `AREA_CARD_A)
        bus_ctl = bc5;
      else if (area == `AREA_CARD_B)
        bus_ctl = bc6;
      else
        bus_ctl = bco;
    end
  endfunction

  function [31:0] wait_ctl;
    input [2:0]  area;
    input [31:0] wc5;
    input [31:0] wc6;
    input [31:0] wco;
    begin
      if (area == `AREA_CARD_A)
        wait_ctl = wc5;
      else if (area == `AREA_CARD_B)
        wait_ctl = wc6;
      else
        wait_ctl = wco;
    end
  endfunction

  // Idle count for the transition from the previous access to this one
  function [1:0] idle_count;
    input [31:0] bc;
    input        prev_write;
    input        cur_write;
    input        same_area;
    begin
      if (prev_write)
        idle_count = bc[`BC_IDLE_AFTER_WRITE];
      else if (cur_write)
        idle_count = same_area ? bc[`BC_IDLE_RD_WR_SAME]
                               : bc[`BC_IDLE_RD_WR_OTHER];
      else
        idle_count = same_area ? bc[`BC_IDLE_RD_RD_SAME]
                               : bc[`BC_IDLE_RD_RD_OTHER];
    end
  endfunction

  wire [2:0]  new_area = req_addr[28:26];
  wire [31:0] new_bc   = bus_ctl(new_area, area5_bus_control_reg,
                           area6_bus_control_reg, area_bus_control_reg);
  wire [31:0] new_wc   = wait_ctl(new_area, area5_wait_control_reg,
                           area6_wait_control_reg, area_wait_control_reg);
  wire [31:0] prev_bc  = bus_ctl(prev_area_reg, area5_bus_control_reg,
                           area6_bus_control_reg, area_bus_control_reg);
  wire [31:0] cur_wc   = wait_ctl(area_reg, area5_wait_control_reg,
                           area6_wait_control_reg, area_wait_control_reg);
  wire [31:0] cur_bc   = bus_ctl(area_reg, area5_bus_control_reg,
                           area6_bus_control_reg, area_bus_control_reg);

  wire new_is_card_area = (new_area == `AREA_CARD_A) ||
                          (new_area == `AREA_CARD_B);
  wire new_card = common_control_reg[`CC_MAP_SELECT] && new_is_card_area
                  && (new_bc[`BC_MEMORY_KIND] == `KIND_PC_CARD);
  // Upper half follows the low kind bit and lower half the high one;
  // this keeps both the per-half example and the all-I/O ranges valid
  wire new_io = new_card && (req_addr[25] ? new_wc[`WC_LOWER_HALF_KIND]
                : new_wc[`WC_UPPER_HALF_KIND]);
  // Width 8 only when software chose it; 16 otherwise
  wire new_narrow = !new_bc[`BC_BUS_WIDTH_HI]
                    && new_bc[`BC_BUS_WIDTH_LO];
  // Setup count of a card area must be loaded at the take edge too
  wire [3:0] new_setup = new_card ? new_wc[`WC_SETUP_DELAY] : 4'h0;

  wire [1:0] new_idle = prev_valid_reg ?
                        idle_count(prev_bc, prev_write_reg, req_write,
                                   prev_area_reg == new_area) : 2'h0;

  wire       style1 = cur_wc[`WC_BYTE_STROBE_STYLE];
  wire [3:0] setup_cnt = card_reg ? cur_wc[`WC_SETUP_DELAY] : 4'h0;
  wire [3:0] hold_cnt  = card_reg ? cur_wc[`WC_END_HOLD] :
                         (style1 && write_reg) ?
                         {2'h0, cur_wc[`WC_WRITE_HOLD]} : 4'h0;
  wire       wait_ok   = wait_sync_reg[1];
  // Only 16-bit area 6 word I/O in little endian may shrink on the fly
  wire       may_split = io_reg && word_reg && !narrow_reg
                         && (area_reg == `AREA_CARD_B)
                         && !common_control_reg[`CC_BIG_ENDIAN]
                         && !cur_bc[`BC_BUS_WIDTH_LO];

  assign req_ready     = state_reg[0];
  assign bus_clock_out = clk;

  cycle_counter #(.W(4)) phase_counter (
    .clk      (clk),
    .reset    (reset),
    .load     (cnt_load),
    .load_val (cnt_val),
    .zero     (cnt_zero)
  );

  always @*
  begin
    state_next = state_reg;
    cnt_load   = 1'b0;
    cnt_val    = 4'h0;
    case (state_reg)
      S_IDLE:
        if (req_valid)
        begin
          cnt_load = 1'b1;
          if (new_idle != 2'h0)
          begin
            state_next = S_GAP;
            cnt_val = {2'h0, new_idle - 2'h1};
          end
          else
          begin
            state_next = S_SETUP;
            cnt_val    = new_setup;
          end
        end
      S_GAP:
        if (cnt_zero)
        begin
          state_next = S_SETUP;
          cnt_load   = 1'b1;
          cnt_val    = setup_cnt;
        end
      S_SETUP:
        if (cnt_zero)
        begin
          state_next = S_STRB;
          cnt_load   = 1'b1;
          cnt_val    = cur_wc[`WC_SOFT_WAIT];
        end
      S_STRB:
        if (cnt_zero && wait_ok)
        begin
          state_next = S_HOLD;
          cnt_load   = 1'b1;
          cnt_val    = hold_cnt;
        end
      S_HOLD:
        if (cnt_zero)
        begin
          if (split_reg && !second_reg)
          begin
            state_next = S_SETUP;
            cnt_load   = 1'b1;
            cnt_val    = setup_cnt;
          end
          else
            state_next = S_DONE;
        end
      S_DONE:
        state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg      <= S_IDLE;
      addr_reg       <= 26'h0000000;
      area_reg       <= 3'h0;
      write_reg      <= 1'b0;
      word_reg       <= 1'b0;
      wdata_reg      <= 16'h0000;
      card_reg       <= 1'b0;
      io_reg         <= 1'b0;
      narrow_reg     <= 1'b0;
      split_reg      <= 1'b0;
      second_reg     <= 1'b0;
      prev_valid_reg <= 1'b0;
      prev_write_reg <= 1'b0;
      prev_area_reg  <= 3'h0;
      req_done       <= 1'b0;
      req_rdata      <= 16'h0000;
      wait_sync_reg  <= 2'h3;
      wide_sync_reg  <= 2'h0;
      sample_reg     <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      req_done      <= state_reg[5];
      wait_sync_reg <= {wait_sync_reg[0], wait_n};
      wide_sync_reg <= {wide_sync_reg[0], card_wide_io_indication};
      if (state_reg[0] && req_valid)
      begin
        addr_reg   <= req_addr[25:0];
        area_reg   <= new_area;
        write_reg  <= req_write;
        word_reg   <= req_word;
        wdata_reg  <= req_wdata;
        card_reg   <= new_card;
        io_reg     <= new_io;
        narrow_reg <= new_narrow;
        split_reg  <= req_word && new_narrow;
        second_reg <= 1'b0;
      end
      // Indication looked at only in the first pass of a wide I/O word
      if (may_split && !second_reg &&
          ((state_reg[2] && setup_cnt >= `SETUP_SAMPLE_MIN) ||
           state_reg[3]) && wide_sync_reg[1])
        split_reg <= 1'b1;
      if (state_reg[4] && cnt_zero && split_reg && !second_reg)
        second_reg <= 1'b1;
      // Pins trail the state by one cycle, so read data is taken one edge
      // after the strobe state ends, while the pin strobe is still low
      sample_reg <= state_reg[3] && cnt_zero && wait_ok && !write_reg;
      if (sample_reg)
      begin
        if (!split_reg)
          req_rdata <= data_in;
        else if (second_reg)
          req_rdata[15:8] <= data_in[7:0];
        else
          req_rdata[7:0] <= data_in[7:0];
      end
      if (state_reg[5])
      begin
        prev_valid_reg <= 1'b1;
        prev_write_reg <= write_reg;
        prev_area_reg  <= area_reg;
      end
    end
  end

  // Pin drive, registered one cycle behind the phase state
  wire active = state_reg[2] | state_reg[3] | state_reg[4];
  wire strobe = state_reg[3];
  wire [1:0] lanes = split_reg ? 2'h1 :
                     word_reg ? 2'h3 :
                     addr_reg[0] ? 2'h2 : 2'h1;
  wire [1:0] card_lanes = (split_reg || narrow_reg) ? 2'h1 : lanes;
  wire       hi_byte = split_reg ? second_reg : (narrow_reg && addr_reg[0]);

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ext_addr              <= 26'h0000000;
      data_out              <= 16'h0000;
      data_oe_n             <= 1'b1;
      area_select_n         <= 8'hFF;
      rd_n                  <= 1'b1;
      rd_wr_n               <= 1'b1;
      byte_enable_n         <= 2'h3;
      card_io_read_n        <= 1'b1;
      card_io_write_n       <= 1'b1;
      slot_a_enable_lower_n <= 1'b1;
      slot_a_enable_upper_n <= 1'b1;
      slot_b_enable_lower_n <= 1'b1;
      slot_b_enable_upper_n <= 1'b1;
    end
    else
    begin
      // A24 passes straight out so it can select attribute memory
      ext_addr <= {addr_reg[25:1], addr_reg[0] | second_reg};
      data_out <= hi_byte ? {8'h00, wdata_reg[15:8]} : wdata_reg;
      data_oe_n <= !(active && write_reg);
      area_select_n <= ~({7'h00, active && !card_reg} << area_reg);
      rd_n <= !(strobe && !write_reg && !io_reg);
      card_io_read_n  <= !(strobe && io_reg && !write_reg);
      card_io_write_n <= !(strobe && io_reg && write_reg);
      if (card_reg)
      begin
        rd_wr_n       <= !(active && write_reg);
        byte_enable_n <= {1'b1, !(strobe && write_reg && !io_reg)};
      end
      else if (style1)
      begin
        rd_wr_n       <= !(strobe && write_reg);
        byte_enable_n <= ~(lanes & {2{active}});
      end
      else
      begin
        rd_wr_n       <= !(active && write_reg);
        byte_enable_n <= ~(lanes & {2{strobe}});
      end
      slot_a_enable_lower_n <= !(active && card_reg && card_lanes[0]
                                 && area_reg == `AREA_CARD_A);
      slot_a_enable_upper_n <= !(active && card_reg && card_lanes[1]
                                 && area_reg == `AREA_CARD_A);
      slot_b_enable_lower_n <= !(active && card_reg && card_lanes[0]
                                 && area_reg == `AREA_CARD_B);
      slot_b_enable_upper_n <= !(active && card_reg && card_lanes[1]
                                 && area_reg == `AREA_CARD_B);
    end
  end

  // Register port: writes take effect at once, read data one cycle later
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      common_control_reg     <= `RST_CONTROL;
      area5_bus_control_reg  <= `RST_CONTROL;
      area6_bus_control_reg  <= `RST_CONTROL;
      area5_wait_control_reg <= `RST_CONTROL;
      area6_wait_control_reg <= `RST_CONTROL;
      area_bus_control_reg   <= `RST_CONTROL;
      area_wait_control_reg  <= `RST_CONTROL;
      reg_rdata              <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `OFS_COMMON_CONTROL:     common_control_reg     <= reg_wdata;
          `OFS_AREA5_BUS_CONTROL:  area5_bus_control_reg  <= reg_wdata;
          `OFS_AREA6_BUS_CONTROL:  area6_bus_control_reg  <= reg_wdata;
          `OFS_AREA5_WAIT_CONTROL: area5_wait_control_reg <= reg_wdata;
          `OFS_AREA6_WAIT_CONTROL: area6_wait_control_reg <= reg_wdata;
          `OFS_AREA_BUS_CONTROL:   area_bus_control_reg   <= reg_wdata;
          `OFS_AREA_WAIT_CONTROL:  area_wait_control_reg  <= reg_wdata;
          default:                 ;
        endcase
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `OFS_COMMON_CONTROL:     reg_rdata <= common_control_reg;
          `OFS_AREA5_BUS_CONTROL:  reg_rdata <= area5_bus_control_reg;
          `OFS_AREA6_BUS_CONTROL:  reg_rdata <= area6_bus_control_reg;
          `OFS_AREA5_WAIT_CONTROL: reg_rdata <= area5_wait_control_reg;
          `OFS_AREA6_WAIT_CONTROL: reg_rdata <= area6_wait_control_reg;
          `OFS_AREA_BUS_CONTROL:   reg_rdata <= area_bus_control_reg;
          `OFS_AREA_WAIT_CONTROL:  reg_rdata <= area_wait_control_reg;
          `OFS_STATUS:
            reg_rdata <= {21'h000000, io_reg, card_reg, second_reg,
                          split_reg, !state_reg[0], state_reg};
          default:                 reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// file: tb/card_sram_port_checker.sv
// Concurrent assertions on the ports of the external bus port
`timescale 1ns/1ps
module card_sram_port_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        req_done,
  input wire logic [25:0] ext_addr,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_n,
  input wire logic [7:0]  area_select_n,
  input wire logic        rd_n,
  input wire logic        rd_wr_n,
  input wire logic [1:0]  byte_enable_n,
  input wire logic        card_io_read_n,
  input wire logic        slot_a_enable_lower_n,
  input wire logic        slot_a_enable_upper_n
);
  // Shadow copies of the few control bits the properties depend on
  logic        map_reg;
  logic [3:0]  kind5_reg;
  logic [20:0] wc5_reg;
  logic [20:0] wco_reg;
  wire         sram_sel = area_select_n[4:0] != 5'h1F;
  wire         io_half = ext_addr[25] ? wc5_reg[0] : wc5_reg[1];

  always @(posedge clk or posedge reset)
    if (reset)
    begin
      map_reg   <= 1'b0;
      kind5_reg <= 4'h0;
      wc5_reg   <= 21'h0;
      wco_reg   <= 21'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h00) map_reg <= reg_wdata[0];
      if (reg_addr == 8'h04) kind5_reg <= reg_wdata[15:12];
      if (reg_addr == 8'h0C) wc5_reg <= reg_wdata[20:0];
      if (reg_addr == 8'h18) wco_reg <= reg_wdata[20:0];
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  done_single_a: assert property (req_done |=> !req_done)
    else $error("done pulse longer than one cycle");
  style0_write_a: assert property (
    !wco_reg[20] && sram_sel && !data_oe_n && byte_enable_n != 2'h3
    |-> !rd_wr_n) else $error("byte strobe outside write cycle");
  style0_read_a: assert property (
    $fell(rd_n) && sram_sel && !wco_reg[20]
    |-> ##[0:3] byte_enable_n != 2'h3)
    else $error("no byte select during read");
  style1_strobe_a: assert property (
    wco_reg[20] && sram_sel && $fell(rd_wr_n) |-> !data_oe_n)
    else $error("write strobe without data");
  write_hold_a: assert property (
    wco_reg[20] && wco_reg[17:16] == 2'h2 && $rose(rd_wr_n) && !data_oe_n
    |-> (!data_oe_n && $stable(data_out)) [*2])
    else $error("write data not held");
  card_mode_a: assert property (
    !slot_a_enable_lower_n || !slot_a_enable_upper_n
    |-> map_reg && kind5_reg == 4'h5) else $error("card enable unexpected");
  io_half_a: assert property (
    !slot_a_enable_lower_n && !card_io_read_n |-> io_half)
    else $error("I/O strobe in memory half");
  mem_half_a: assert property (
    !slot_a_enable_lower_n && !rd_n |-> !io_half)
    else $error("memory strobe in I/O half");
  soft_wait_a: assert property (
    $fell(card_io_read_n) && wc5_reg[5:2] == 4'h2 && !slot_a_enable_lower_n
    |-> !card_io_read_n [*3]) else $error("soft wait too short");
endmodule

bind card_sram_port card_sram_port_checker i_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .req_done(req_done), .ext_addr(ext_addr),
  .data_out(data_out), .data_oe_n(data_oe_n),
  .area_select_n(area_select_n), .rd_n(rd_n), .rd_wr_n(rd_wr_n),
  .byte_enable_n(byte_enable_n), .card_io_read_n(card_io_read_n),
  .slot_a_enable_lower_n(slot_a_enable_lower_n),
  .slot_a_enable_upper_n(slot_a_enable_upper_n)
);

// file: tb/card_mem_model.sv
// Behavioural byte-select SRAM and PC card sitting on the external pins
`timescale 1ns/1ps
module card_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [25:0] ext_addr,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_n,
  input  wire logic        rd_n,
  input  wire logic        rd_wr_n,
  input  wire logic [1:0]  byte_enable_n,
  input  wire logic        card_io_read_n,
  input  wire logic        card_io_write_n,
  output logic      [15:0] data_in,
  output logic             wait_n
);
  logic [7:0]  mem [0:255];
  logic [15:0] last = 16'h0000;
  int          stall = 0;
  wire  [7:0]  a = {ext_addr[7:1], 1'b0};
  wire         rd_act = !rd_n || !card_io_read_n;
  wire         wr_act = !data_oe_n && (byte_enable_n != 2'h3 ||
                        !rd_wr_n || !card_io_write_n);
  wire         all_ln = byte_enable_n == 2'h3;

  // Released bus shows the inverse of the last value, never a stale copy
  assign data_in = rd_act ? {mem[a + 8'h01], mem[a]} : ~last;
  // Slow device pulls wait low for the first three strobe cycles
  assign wait_n = !(slow && (rd_act || wr_act) && stall < 3);

  always @(posedge clk)
  begin
    stall <= (rd_act || wr_act) ? stall + 1 : 0;
    if (rd_act) last <= data_in;
    if (wr_act && (all_ln || !byte_enable_n[0])) mem[a] <= data_out[7:0];
    if (wr_act && (all_ln || !byte_enable_n[1]))
      mem[a + 8'h01] <= data_out[15:8];
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the external bus port
`timescale 1ns/1ps
module tb_top;
  logic        clk, reset, reg_wr, reg_rd, req_valid, req_write, req_word;
  logic        ind, slow;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, v;
  logic [28:0] req_addr;
  logic [15:0] req_wdata, q;
  wire  [31:0] reg_rdata;
  wire  [15:0] req_rdata, data_out, data_in;
  wire  [25:0] ext_addr;
  wire  [7:0]  area_select_n;
  wire  [1:0]  byte_enable_n;
  wire         req_ready, req_done, data_oe_n, rd_n, rd_wr_n, wait_n;
  wire         io_rd_n, io_wr_n, a_lo_n, a_hi_n, b_lo_n, b_hi_n;
  int          errors = 0, cmp_count = 0, cyc = 0, lat, l0, nio, nen, i;
  localparam [28:0] A1 = 29'h0400_0000, A2 = 29'h0800_0000;

  card_sram_port i_card_sram_port (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
    .req_word(req_word), .req_wdata(req_wdata), .req_ready(req_ready),
    .req_done(req_done), .req_rdata(req_rdata), .bus_clock_out(),
    .ext_addr(ext_addr), .data_out(data_out), .data_in(data_in),
    .data_oe_n(data_oe_n), .area_select_n(area_select_n), .rd_n(rd_n),
    .rd_wr_n(rd_wr_n), .byte_enable_n(byte_enable_n),
    .card_io_read_n(io_rd_n), .card_io_write_n(io_wr_n),
    .slot_a_enable_lower_n(a_lo_n), .slot_a_enable_upper_n(a_hi_n),
    .slot_b_enable_lower_n(b_lo_n), .slot_b_enable_upper_n(b_hi_n),
    .wait_n(wait_n), .card_wide_io_indication(ind));

  card_mem_model i_card_mem_model (
    .clk(clk), .slow(slow), .ext_addr(ext_addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .rd_n(rd_n), .rd_wr_n(rd_wr_n),
    .byte_enable_n(byte_enable_n), .card_io_read_n(io_rd_n),
    .card_io_write_n(io_wr_n), .data_in(data_in), .wait_n(wait_n));

  always @(negedge (io_rd_n & io_wr_n)) nio++;
  always @(negedge (a_lo_n & a_hi_n & b_lo_n & b_hi_n)) nen++;

  task automatic chk(input string n, input [31:0] e, input [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One idle cycle after each strobe keeps back-to-back calls race free
  task automatic wr_reg(input [7:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask

  // Latency counts edges from the taking edge to the done pulse
  task automatic xfer(input [28:0] a, input w, input [15:0] d);
    nio = 0;
    nen = 0;
    lat = 0;
    req_addr <= a;
    req_write <= w;
    req_wdata <= d;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      #1 lat++;
    end while (req_done !== 1'b1 && lat < 200);
    q = req_rdata;
    if (lat >= 200) errors++;
    @(posedge clk);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end

  initial
  begin
    {reset, reg_wr, reg_rd, req_valid, req_write, ind, slow} = 7'h40;
    {reg_addr, reg_wdata, req_addr, req_wdata} = '0;
    req_word = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_reg(8'h18);
    chk("wait_ctl_reset", 0, v);
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_reg(8'h40);
    chk("unmapped", 0, v);
    xfer(A1, 1, 16'hA55A);
    xfer(A1, 0, 0);
    chk("style0_data", 16'hA55A, q);
    wr_reg(8'h18, 32'h0012_0000);
    xfer(A1 + 2, 1, 16'h3CC3);
    xfer(A1 + 2, 0, 0);
    chk("style1_data", 16'h3CC3, q);
    wr_reg(8'h18, 0);
    // Each transition type gets three idle cycles from its own field
    for (i = 0; i < 5; i++)
    begin
      wr_reg(8'h14, 0);
      xfer(A1, i == 0, 16'h1111);
      xfer((i == 1 || i == 3) ? A2 : A1, i == 1 || i == 2, 16'h2222);
      l0 = lat;
      wr_reg(8'h14, 32'h3 << (28 - 2 * i));
      xfer(A1, i == 0, 16'h1111);
      xfer((i == 1 || i == 3) ? A2 : A1, i == 1 || i == 2, 16'h2222);
      chk("idle_gap", l0 + 3, lat);
    end
    wr_reg(8'h14, 0);
    wr_reg(8'h04, 32'h0000_5400);
    wr_reg(8'h0C, 32'h0000_0003);
    xfer(29'h1400_0000, 0, 0);
    chk("card_off_en", 0, nen);
    wr_reg(8'h00, 32'h0000_0001);
    xfer(29'h1400_0000, 0, 0);
    l0 = lat;
    chk("io_lower", 1, nio);
    xfer(29'h1600_0000, 1, 16'h0F0F);
    chk("io_upper", 1, nio);
    wr_reg(8'h0C, 32'h0000_0002);
    xfer(29'h1600_0000, 0, 0);
    chk("mem_upper_io", 0, nio);
    chk("mem_upper_en", 1, nen);
    wr_reg(8'h0C, 32'h0000_0083);
    xfer(29'h1400_0000, 0, 0);
    chk("setup_delay", l0 + 2, lat);
    wr_reg(8'h0C, 32'h0000_000B);
    xfer(29'h1400_0000, 0, 0);
    chk("soft_wait", l0 + 2, lat);
    // Synchronised wait is seen only from the strobe cycle after the third soft wait cycle on
    wr_reg(8'h0C, 32'h0000_000F);
    xfer(29'h1400_0000, 0, 0);
    chk("soft_wait3", l0 + 3, lat);
    slow <= 1'b1;
    xfer(29'h1400_0000, 0, 0);
    slow <= 1'b0;
    chk("hw_wait", l0 + 6, lat);
    wr_reg(8'h08, 32'h0000_5400);
    wr_reg(8'h10, 32'h0000_0083);
    ind <= 1'b1;
    xfer(29'h1800_0000, 0, 0);
    chk("wide_split", 2, nio);
    ind <= 1'b0;
    // Let the indication clear its synchroniser before the next take
    repeat (2) @(posedge clk);
    xfer(29'h1A00_0000, 0, 0);
    chk("wide_single", 1, nio);
    conclude();
  end
endmodule
